// ==== verilog/bsi_params.svh ====
/*
 * Register offsets, field positions, reset values and masks of the
 * command streamer interrupt and error reporting block.
 * Assumes a byte-addressed register port with 32-bit data words.
 */
`ifndef BSI_PARAMS_SVH
`define BSI_PARAMS_SVH

`define BSI_OFF_STATUS_PAGE_WRITE_MASK 20'h2_2098
`define BSI_OFF_INTERRUPT_MASK         20'h2_20a8
`define BSI_OFF_ERROR_IDENTITY         20'h2_20b0
`define BSI_OFF_ERROR_MASK             20'h2_20b4
`define BSI_OFF_ERROR_RAW_STATUS       20'h2_20b8
`define BSI_OFF_BATCH_HEAD_POINTER     20'h2_2140
`define BSI_OFF_WAIT_FLIP_FLAGS        20'h2_22d0
`define BSI_OFF_INTERRUPT_STATUS       20'h2_2080
`define BSI_OFF_INTERRUPT_IDENTITY     20'h2_20a4

`define BSI_RST_STATUS_PAGE_WRITE_MASK 32'h0fff_ffff
`define BSI_RST_INTERRUPT_MASK         32'h0fff_ffff
`define BSI_RST_ERROR_MASK             32'h0000_ffff
`define BSI_RST_ZERO                   32'h0000_0000

`define BSI_BIT_MASTER_ERROR   25
`define BSI_BIT_USER_EVENT     22
`define BSI_BIT_INSTR_ERROR    0
`define BSI_ERR_DEFINED        16'h0001
`define BSI_INT_DEFINED        32'h0240_0000
`define BSI_WFF_WRITABLE       32'h7fff_ffff
`define BSI_BATCH_ADDR_MASK    32'hffff_fff8

`endif

// ==== verilog/bsi_pkg.sv ====
/*
 * Types shared by the interrupt and error reporting block.
 * Assumes bsi_params.svh is available on the include path.
 */
package bsi_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [31:0] wdata;
  } bsi_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } bsi_rsp_t;

  typedef struct packed {
    logic        user_event;
    logic        instr_error;
    logic        batch_active;
    logic [31:3] batch_addr;
  } bsi_eng_t;

  typedef enum logic {BSI_IDLE, BSI_ANSWER} bsi_state_t;
endpackage : bsi_pkg

// ==== verilog/bsi_status_write.sv ====
/*
 * Status page writer: posts the interrupt status word to the hardware
 * status page when a source enabled by the status page write mask rises.
 * Assumes the memory side accepts a posted write each cycle.
 */
`timescale 1ns/100ps
`include "bsi_params.svh"

module bsi_status_write
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] status_i,
  input  wire logic [31:0] page_mask_i,
  input  wire logic [31:0] int_mask_i,
  output logic             write_o,
  output logic [31:0]      data_o
);
  logic [31:0] prev_reg;
  wire  [31:0] rise_w  = status_i & ~prev_reg;
  // Page mask alone decides the write; the interrupt mask is software's duty
  wire  [31:0] allow_w = rise_w & ~page_mask_i;
  wire  [31:0] unused_w = int_mask_i;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= `BSI_RST_ZERO;
      write_o  <= 1'b0;
      data_o   <= `BSI_RST_ZERO;
    end
    else
    begin
      prev_reg <= status_i;
      write_o  <= |allow_w;
      data_o   <= status_i;
    end
  end
endmodule : bsi_status_write

// ==== verilog/bsi_irq_report.sv ====
/*
 * Interrupt and error reporting registers of the blitter command streamer.
 * Assumes a single-cycle register port: one read or write per request,
 * answered one cycle later; engine events arrive synchronous to mclk_i.
 */
`timescale 1ns/100ps
`include "bsi_params.svh"

// Function
// - User event instruction sets user status bit; execution continues.
// - Status page write allowed where status page mask bit is zero.
// - Status bit enters interrupt identity only when interrupt mask is zero.
// - Raw error copied into error identity only when error mask unmasks.
// - Masked errors never reach identity, master error or interrupt.
// - Master error bit is OR of defined error identity bits.
// - Error identity bits stay set until reset; write-one clears are ignored.
// - Shared error layout: bit 0 instruction error, others read zero except error mask bits 15:1.
// - Instruction parser error raises instruction error condition.
// - Raw error status is read-only, shows live conditions.
// - Batch head pointer read-only: address bits 31:3, valid bit 0.
// - Wait flip flags kept across context save; bit 31 reserved.
module bsi_irq_report
  import bsi_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire bsi_pkg::bsi_req_t req_i,
  input  wire bsi_pkg::bsi_eng_t eng_i,
  output bsi_pkg::bsi_rsp_t      rsp_o,
  output logic                   irq_o,
  output logic                   page_write_o,
  output logic [31:0]            page_data_o
);
  import bsi_pkg::*;

  logic [31:0] page_mask_reg;
  logic [31:0] int_mask_reg;
  logic [31:0] int_ident_reg;
  logic        user_event_reg;
  logic [15:0] err_ident_reg;
  logic [15:0] err_mask_reg;
  logic [31:0] wait_flip_reg;
  logic [31:0] batch_reg;
  bsi_rsp_t    rsp_reg;
  logic        irq_reg;

  // Decode
  wire wr_page   = req_i.wr && (req_i.addr == `BSI_OFF_STATUS_PAGE_WRITE_MASK);
  wire wr_imask  = req_i.wr && (req_i.addr == `BSI_OFF_INTERRUPT_MASK);
  wire wr_iident = req_i.wr && (req_i.addr == `BSI_OFF_INTERRUPT_IDENTITY);
  wire wr_eident = req_i.wr && (req_i.addr == `BSI_OFF_ERROR_IDENTITY);
  wire wr_emask  = req_i.wr && (req_i.addr == `BSI_OFF_ERROR_MASK);
  wire wr_wflip  = req_i.wr && (req_i.addr == `BSI_OFF_WAIT_FLIP_FLAGS);

  // Live error conditions, only the defined bit can be nonzero
  wire [15:0] err_raw_w = {15'h0000, eng_i.instr_error} & `BSI_ERR_DEFINED;
  wire [15:0] err_set_w = err_raw_w & ~err_mask_reg;
  // Fatal bit ignores write-one clears
  wire [15:0] err_clr_w = wr_eident ? (req_i.wdata[15:0] & ~`BSI_ERR_DEFINED) : 16'h0000;
  wire [15:0] err_ident_next = ((err_ident_reg & ~err_clr_w) | err_set_w) & `BSI_ERR_DEFINED;

  wire        master_err_w = |err_ident_reg;
  wire [31:0] int_status_w = ({31'h0, master_err_w} << `BSI_BIT_MASTER_ERROR)
                           | ({31'h0, user_event_reg} << `BSI_BIT_USER_EVENT);
  wire        user_clr_w = wr_iident && req_i.wdata[`BSI_BIT_USER_EVENT];
  // Sticky status being cleared now must not re-arm its own identity bit
  wire [31:0] int_src_w = user_clr_w ? (int_status_w & ~(32'h0000_0001 << `BSI_BIT_USER_EVENT)) : int_status_w;
  wire [31:0] int_set_w = int_src_w & ~int_mask_reg;
  wire [31:0] int_clr_w = wr_iident ? req_i.wdata : 32'h0000_0000;
  // Set wins over a same-cycle clear
  wire [31:0] int_ident_next = ((int_ident_reg & ~int_clr_w) | int_set_w) & `BSI_INT_DEFINED;

  // Write to the pointer is dropped; it is hardware owned
  wire [31:0] batch_next = ({eng_i.batch_addr, 3'b000} & `BSI_BATCH_ADDR_MASK)
                         | {31'h0, eng_i.batch_active};

  wire [31:0] rd_data_w =
      (req_i.addr == `BSI_OFF_STATUS_PAGE_WRITE_MASK) ? page_mask_reg :
      (req_i.addr == `BSI_OFF_INTERRUPT_MASK)         ? int_mask_reg :
      (req_i.addr == `BSI_OFF_INTERRUPT_IDENTITY)     ? int_ident_reg :
      (req_i.addr == `BSI_OFF_INTERRUPT_STATUS)       ? int_status_w :
      (req_i.addr == `BSI_OFF_ERROR_IDENTITY)         ? {16'h0000, err_ident_reg} :
      (req_i.addr == `BSI_OFF_ERROR_MASK)             ? {16'h0000, err_mask_reg} :
      (req_i.addr == `BSI_OFF_ERROR_RAW_STATUS)       ? {16'h0000, err_raw_w} :
      (req_i.addr == `BSI_OFF_BATCH_HEAD_POINTER)     ? batch_reg :
      (req_i.addr == `BSI_OFF_WAIT_FLIP_FLAGS)        ? wait_flip_reg :
                                                        32'h0000_0000;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      page_mask_reg  <= `BSI_RST_STATUS_PAGE_WRITE_MASK;
      int_mask_reg   <= `BSI_RST_INTERRUPT_MASK;
      int_ident_reg  <= `BSI_RST_ZERO;
      user_event_reg <= 1'b0;
      err_ident_reg  <= 16'h0000;
      err_mask_reg   <= 16'hffff;
      wait_flip_reg  <= `BSI_RST_ZERO;
      batch_reg      <= `BSI_RST_ZERO;
      rsp_reg        <= '0;
      irq_reg        <= 1'b0;
    end
    else
    begin
      if (wr_page)
        page_mask_reg <= req_i.wdata;
      if (wr_imask)
        int_mask_reg <= req_i.wdata;
      if (wr_emask)
        err_mask_reg <= req_i.wdata[15:0];
      // Bit 31 reserved; the value rides through context save untouched
      if (wr_wflip)
        wait_flip_reg <= req_i.wdata & `BSI_WFF_WRITABLE;
      // Status bit stays up until the identity bit is cleared by software
      if (eng_i.user_event)
        user_event_reg <= 1'b1;
      else if (user_clr_w)
        user_event_reg <= 1'b0;
      err_ident_reg <= err_ident_next;
      int_ident_reg <= int_ident_next;
      batch_reg     <= batch_next;
      rsp_reg.valid <= req_i.rd;
      rsp_reg.rdata <= req_i.rd ? rd_data_w : 32'h0000_0000;
      irq_reg       <= |int_ident_next;
    end
  end

  assign rsp_o = rsp_reg;
  assign irq_o = irq_reg;

  bsi_status_write u_status_write
  (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .status_i    (int_status_w),
    .page_mask_i (page_mask_reg),
    .int_mask_i  (int_mask_reg),
    .write_o     (page_write_o),
    .data_o      (page_data_o)
  );
endmodule : bsi_irq_report

// ==== dv/bsi_irq_report_properties.sv ====
/* Port checker for the interrupt and error reporting block.
   Assumes it is bound to bsi_irq_report and sees only its ports. */
`timescale 1ns/100ps
module bsi_irq_report_properties
  import bsi_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire bsi_pkg::bsi_req_t req_i,
  input wire bsi_pkg::bsi_eng_t eng_i,
  input wire bsi_pkg::bsi_rsp_t rsp_o,
  input wire logic              irq_o,
  input wire logic              page_write_o,
  input wire logic [31:0]       page_data_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_READ_ANSWER: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read not answered");
  AST_RAW_LIVE: assert property (req_i.rd && req_i.addr == 20'h2_20b8 |=>
    rsp_o.rdata == {31'h0, $past(eng_i.instr_error)}) else $error("raw error status wrong");
  AST_ERR_ID_LAYOUT: assert property (req_i.rd && req_i.addr == 20'h2_20b0 |=>
    rsp_o.rdata[31:1] == '0) else $error("error identity reserved bits set");
  AST_ERR_MASK_LAYOUT: assert property (req_i.rd && req_i.addr == 20'h2_20b4 |=>
    rsp_o.rdata[31:16] == '0) else $error("error mask upper bits set");
  AST_BATCH_PTR: assert property (req_i.rd && req_i.addr == 20'h2_2140 |=>
    rsp_o.rdata == {$past(eng_i.batch_addr, 2), 2'b00, $past(eng_i.batch_active, 2)})
    else $error("batch pointer wrong");
  AST_WFF_RSVD: assert property (req_i.rd && req_i.addr == 20'h2_22d0 |=> !rsp_o.rdata[31])
    else $error("wait flag bit 31 set");
  AST_PAGE_DATA: assert property (page_write_o |-> page_data_o != '0 &&
    (page_data_o & 32'hfdbf_ffff) == '0) else $error("status page word wrong");
  // Identity clear lands at the edge that takes the write
  AST_IRQ_HOLD: assert property (irq_o && !req_i.wr && !$past(req_i.wr) |=> irq_o)
    else $error("interrupt dropped without clear");
  cover property (page_write_o);
  cover property (irq_o);
  cover property (rsp_o.valid && rsp_o.rdata[0]);
endmodule : bsi_irq_report_properties

bind bsi_irq_report bsi_irq_report_properties u_props (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
  .eng_i(eng_i), .rsp_o(rsp_o), .irq_o(irq_o), .page_write_o(page_write_o), .page_data_o(page_data_o));

// ==== dv/tb_blit_stream_irq_error_report.sv ====
/* Self-checking bench for the interrupt and error reporting block.
   Assumes bsi_pkg and the design are compiled before it. */
`timescale 1ns/100ps
module tb_blit_stream_irq_error_report;
  import bsi_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  bsi_req_t    req    = '0;
  bsi_eng_t    eng    = '0;
  bsi_rsp_t    rsp;
  logic        irq, pw;
  logic [31:0] pd, v;
  int          failures = 0;
  int          compares = 0;
  bsi_irq_report DUT (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .eng_i(eng), .rsp_o(rsp), .irq_o(irq),
                      .page_write_o(pw), .page_data_o(pd));
  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk_i);
    req.wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [19:0] a, input logic [31:0] e);
    @(negedge mclk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(negedge mclk_i);
    req.rd = 1'b0;
    check("read valid", {31'h0, rsp.valid}, 32'h0000_0001);
    check($sformatf("reg %h", a), rsp.rdata, e);
  endtask : rdc
  task automatic t_reset;
    rdc(20'h2_2098, 32'h0fff_ffff);
    rdc(20'h2_20a8, 32'h0fff_ffff);
    rdc(20'h2_20b4, 32'h0000_ffff);
    rdc(20'h2_20b0, 32'h0000_0000);
    rdc(20'h2_1000, 32'h0000_0000);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_user;
    v = '0;
    wr(20'h2_2098, 32'h0fbf_ffff);
    wr(20'h2_20a8, 32'h0fbf_ffff);
    @(negedge mclk_i);
    eng.user_event = 1'b1;
    @(negedge mclk_i);
    eng.user_event = 1'b0;
    repeat (3) @(negedge mclk_i) if (pw === 1'b1) v = {31'h0, pd[22]};
    check("page write", v, 32'h0000_0001);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    rdc(20'h2_2080, 32'h0040_0000);
    rdc(20'h2_20a4, 32'h0040_0000);
    wr(20'h2_20a4, 32'h0040_0000);
    wr(20'h2_20a8, 32'h0fff_ffff);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    @(negedge mclk_i);
    eng.user_event = 1'b1;
    @(negedge mclk_i);
    eng.user_event = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    $display("test user event done");
  endtask : t_user
  task automatic t_error;
    @(negedge mclk_i);
    eng.instr_error = 1'b1;
    rdc(20'h2_20b8, 32'h0000_0001);
    rdc(20'h2_20b0, 32'h0000_0000);
    wr(20'h2_20b4, 32'h0000_0000);
    wr(20'h2_20a8, 32'h0dff_ffff);
    repeat (3) @(negedge mclk_i);
    check("irq error", {31'h0, irq}, 32'h0000_0001);
    rdc(20'h2_20b0, 32'h0000_0001);
    rdc(20'h2_2080, 32'h0240_0000);
    eng.instr_error = 1'b0;
    wr(20'h2_20b0, 32'hffff_ffff);
    rdc(20'h2_20b0, 32'h0000_0001);
    rdc(20'h2_20b8, 32'h0000_0000);
    wr(20'h2_20a4, 32'h0200_0000);
    check("master error kept", {31'h0, irq}, 32'h0000_0001);
    $display("test error chain done");
  endtask : t_error
  task automatic t_misc;
    @(negedge mclk_i);
    eng.batch_active = 1'b1;
    eng.batch_addr = 29'h1234_5678;
    rdc(20'h2_2140, 32'h91a2_b3c1);
    wr(20'h2_22d0, 32'hffff_ffff);
    rdc(20'h2_22d0, 32'h7fff_ffff);
    @(negedge mclk_i);
    rst_i = 1'b1;
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    rdc(20'h2_20b0, 32'h0000_0000);
    $display("test pointer and flags done");
  endtask : t_misc
  initial
  begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    t_reset();
    t_user();
    t_error();
    t_misc();
    finish_test();
  end
  initial
  begin
    repeat (2000) @(posedge mclk_i);
    failures++;
    finish_test();
  end
endmodule : tb_blit_stream_irq_error_report
